// ===== verilog/ces_capture.sv
// syndrome builder and capture register for coherence interconnect errors
`timescale 1ns/1ps

module ces_capture
  import ces_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        err_valid,
  input  wire logic [3:0]  err_kind,
  input  wire ces_req_t    err_req,
  input  wire ces_loc_t    err_loc,
  input  wire ces_dec_t    err_dec,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic [57:0]      error_detail_field,
  output logic [3:0]       error_kind,
  output logic             error_held
);

  ces_state_t s_q;
  ces_state_t s_d;
  logic [57:0] syn;
  logic        clr;

  ////////////////////////////////////////////////////////////////////////
  // reserved type codes are squashed to the no-data request code so that
  // software never sees an undefined transaction type
  function automatic ces_txn_type_t legal_type(input ces_txn_type_t t);
    unique case (t)
      type_rsvd_1, type_rsvd_3: legal_type = plain_request_nodata;
      default:                  legal_type = t;
    endcase
  endfunction

  // common low fields shared by every kind but fetch-lock upper bits
  function automatic logic [27:0] low_fields(input ces_req_t r,
                                             input logic     dual);
    logic [27:0] f;
    f = 28'h000_0000;
    f[CES_PORT_HI:CES_PORT_LO] = r.port;
    f[CES_HART_HI:CES_HART_LO] = {2'b00, r.hart[1:0]};
    f[CES_CMD_HI:CES_CMD_LO]   = r.cmd;
    f[CES_GRP_HI:CES_GRP_LO]   = r.grp;
    f[CES_ATTR_HI:CES_ATTR_LO] = r.attr;
    // the two reserved sizes never occur; recorded as given
    f[CES_SIZE_HI:CES_SIZE_LO] = r.size;
    f[CES_TYPE_HI:CES_TYPE_LO] = legal_type(r.ttype);
    f[CES_SCHED]               = dual & r.sched;
    low_fields = f;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // syndrome assembly; every unassigned bit stays zero
  always_comb begin
    syn = CES_DETAIL_RST;
    syn[27:0] = low_fields(err_req, s_q.dual);
    unique case (err_kind)
      CES_KIND_ECC_A, CES_KIND_ECC_B: begin
        syn[CES_ECC_KIND_BIT]    = err_loc.is_data;
        syn[CES_DW_HI:CES_DW_LO] = err_loc.dword;
        syn[CES_WAY_HI:CES_WAY_LO] = err_loc.way;
        syn[CES_SET_HI:CES_SET_LO] = {3'b000, err_loc.set[12:0]};
        syn[CES_BANK]              = err_loc.bank;
      end
      CES_KIND_DECODE: begin
        syn[CES_D_GICFETCH] = err_dec.gic_fetch;
        syn[CES_D_NCMMIO]   = err_dec.nc_mmio;
        syn[CES_D_CMMIO]    = err_dec.coh_mmio;
        // register access must be uncached and not linked
        syn[CES_D_ATTR] = err_dec.linked_load_cond_store
                        | (err_dec.norm && err_req.attr != uncached_attr);
        // register access must be four or eight bytes
        syn[CES_D_SIZE] = err_dec.norm && err_req.size != CES_SIZE_4B
                        && err_req.size != CES_SIZE_8B;
        syn[CES_D_MULTI]  = err_dec.multi;
        syn[CES_D_COHREG] = err_dec.coh_reg;
        syn[CES_D_DBG]    = err_dec.dbg;
        syn[CES_D_FDC]    = err_dec.fdc;
        syn[CES_D_NORM]   = err_dec.norm;
        syn[CES_D_GCR:CES_D_IO_COHERENCE_UNIT]     = err_dec.hit;
        syn[CES_DCMD_HI:CES_DCMD_LO]  = err_dec.dcmd;
        syn[CES_DGRP_HI:CES_DGRP_LO]  = err_dec.dgrp;
        syn[CES_DDST_HI:CES_DDST_LO]  = err_dec.ddst;
      end
      CES_KIND_PARITY: begin
        syn[CES_PDW_HI:CES_PDW_LO] = err_loc.dword;
      end
      default: begin
        // fetch-lock and others: upper bits reserved
        syn[57:28] = 30'h0000_0000;
        syn[CES_BANK] = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // first error wins; later ones are dropped until software clears, so a
  // burst of errors cannot overwrite the root cause
  assign clr = reg_wr && reg_addr == CES_REG_CTRL && reg_wdata[1];

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    if (clr) begin
      s_d.valid  = 1'b0;
      s_d.kind   = CES_KIND_RST;
      s_d.detail = CES_DETAIL_RST;
    end
    // capture beats clear in the same cycle
    if (err_valid && (!s_q.valid || clr)) begin
      s_d.valid  = 1'b1;
      s_d.kind   = err_kind;
      s_d.detail = syn;
    end
    if (reg_wr && reg_addr == CES_REG_CTRL) begin
      s_d.dual = reg_wdata[0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        CES_REG_LO:   s_d.rdata = s_q.detail[31:0];
        CES_REG_HI:   s_d.rdata = {6'h00, s_q.detail[57:32]};
        CES_REG_STAT: s_d.rdata = {24'h00_0000, s_q.kind, 3'b000,
                                   s_q.valid};
        CES_REG_CTRL: s_d.rdata = {31'h0000_0000, s_q.dual};
        default:      s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata          = s_q.rdata;
  assign error_detail_field = s_q.detail;
  assign error_kind         = s_q.kind;
  assign error_held         = s_q.valid;

endmodule // ces_capture

// ===== include/ces_pkg.sv
// package for the coherence error syndrome capture block
package ces_pkg;

  // transaction type codes
  typedef enum logic [3:0] {
    plain_request_nodata        = 4'h0,
    type_rsvd_1                 = 4'h1,
    plain_request_with_data     = 4'h2,
    type_rsvd_3                 = 4'h3,
    intervene_req_no_reply      = 4'h4,
    intervene_req_reply         = 4'h5,
    intervene_req_data_no_reply = 4'h6,
    intervene_req_data_reply    = 4'h7,
    plain_reply_nodata          = 4'h8,
    plain_reply_data_later      = 4'h9,
    plain_reply_with_data       = 4'hA,
    plain_reply_data_only       = 4'hB,
    intervene_reply_nodata      = 4'hC,
    intervene_reply_data_later  = 4'hD,
    intervene_reply_with_data   = 4'hE,
    intervene_reply_data_only   = 4'hF
  } ces_txn_type_t;

  // error kinds
  localparam logic [3:0] CES_KIND_ECC_A  = 4'h1;
  localparam logic [3:0] CES_KIND_DECODE = 4'h2;
  localparam logic [3:0] CES_KIND_ECC_B  = 4'h3;
  localparam logic [3:0] CES_KIND_PARITY = 4'h4;
  localparam logic [3:0] CES_KIND_FLOCK  = 4'h5;

  // sizes: exponent of bytes
  localparam logic [2:0] CES_SIZE_4B   = 3'h2;
  localparam logic [2:0] CES_SIZE_8B   = 3'h3;
  localparam logic [2:0] CES_SIZE_32B  = 3'h5;
  localparam logic [2:0] CES_SIZE_128B = 3'h7;
  localparam logic [2:0] CES_SIZE_RPL  = 3'h6;
  localparam logic [2:0] uncached_attr = 3'h2;

  localparam int CES_DATA_LAT = 3; // data beat follows reply by this many
  localparam logic [57:0] CES_DETAIL_RST = 58'h0;
  localparam logic [3:0]  CES_KIND_RST   = 4'h0;

  // field positions of the detail word
  localparam int CES_ECC_KIND_BIT = 57;
  localparam int CES_DW_HI   = 56;
  localparam int CES_DW_LO   = 49;
  localparam int CES_WAY_HI  = 48;
  localparam int CES_WAY_LO  = 45;
  localparam int CES_SET_HI  = 44;
  localparam int CES_SET_LO  = 29;
  localparam int CES_BANK    = 28;
  localparam int CES_PORT_HI = 27;
  localparam int CES_PORT_LO = 22;
  localparam int CES_HART_HI = 21;
  localparam int CES_HART_LO = 18;
  localparam int CES_CMD_HI  = 17;
  localparam int CES_CMD_LO  = 14;
  localparam int CES_GRP_HI  = 13;
  localparam int CES_GRP_LO  = 11;
  localparam int CES_ATTR_HI = 10;
  localparam int CES_ATTR_LO = 8;
  localparam int CES_SIZE_HI = 7;
  localparam int CES_SIZE_LO = 5;
  localparam int CES_TYPE_HI = 4;
  localparam int CES_TYPE_LO = 1;
  localparam int CES_SCHED   = 0;
  localparam int CES_D_GICFETCH = 56;
  localparam int CES_D_NCMMIO   = 55;
  localparam int CES_D_CMMIO    = 54;
  localparam int CES_D_ATTR     = 52;
  localparam int CES_D_SIZE     = 51;
  localparam int CES_D_MULTI    = 50;
  localparam int CES_D_COHREG   = 49;
  localparam int CES_D_DBG      = 48;
  localparam int CES_D_FDC      = 47;
  localparam int CES_D_NORM     = 46;
  localparam int CES_D_GCR      = 45;
  localparam int CES_D_UGCR     = 44;
  localparam int CES_D_CPC      = 43;
  localparam int CES_D_GIC      = 42;
  localparam int CES_D_IO_COHERENCE_UNIT     = 41;
  localparam int CES_DCMD_HI = 40;
  localparam int CES_DCMD_LO = 37;
  localparam int CES_DGRP_HI = 36;
  localparam int CES_DGRP_LO = 34;
  localparam int CES_DDST_HI = 33;
  localparam int CES_DDST_LO = 28;
  localparam int CES_PDW_HI  = 35;
  localparam int CES_PDW_LO  = 28;

  // register map on the plain port (word index = byte addr / 4)
  localparam logic [3:0] CES_REG_LO   = 4'h0; // detail 31:0
  localparam logic [3:0] CES_REG_HI   = 4'h4; // detail 57:32
  localparam logic [3:0] CES_REG_STAT = 4'h8; // 0 valid, 7:4 kind
  localparam logic [3:0] CES_REG_CTRL = 4'hC; // 0 dual scheduler, 1 clr

  // requester-side attributes of the failing transaction
  typedef struct packed {
    logic [5:0]    port;
    logic [3:0]    hart;
    logic [3:0]    cmd;
    logic [2:0]    grp;
    logic [2:0]    attr;
    logic [2:0]    size;
    ces_txn_type_t ttype;
    logic          sched;
  } ces_req_t;

  // location for ecc and parity errors
  typedef struct packed {
    logic        is_data;
    logic [7:0]  dword;
    logic [3:0]  way;
    logic [15:0] set;
    logic        bank;
  } ces_loc_t;

  // decode-error cause and onward request
  typedef struct packed {
    logic       gic_fetch;
    logic       nc_mmio;
    logic       coh_mmio;
    logic       linked_load_cond_store;
    logic       multi;
    logic       coh_reg;
    logic       dbg;
    logic       fdc;
    logic       norm;
    logic [4:0] hit;   // gcr, user gcr, power, irq, io unit
    logic [3:0] dcmd;
    logic [2:0] dgrp;
    logic [5:0] ddst;
  } ces_dec_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  kind;
    logic [57:0] detail;
    logic [31:0] rdata;
    logic        dual;
  } ces_state_t;

endpackage

// ===== tb/ces_capture_chk.sv
// assertions on the ports of the syndrome capture block
`timescale 1ns/1ps

module ces_capture_chk
  import ces_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        err_valid,
  input wire logic [3:0]  err_kind,
  input wire ces_req_t    err_req,
  input wire ces_loc_t    err_loc,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [57:0] error_detail_field,
  input wire logic        error_held
);
  logic tk;
  logic ecc;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // tk marks a report taken while nothing is held; captures in a cycle that clears are not counted here
  assign tk  = err_valid && !error_held;
  assign ecc = tk && (err_kind == 4'h1 || err_kind == 4'h3);

  //////////////////////////////////////////////////////////////////////////
  AST_ECC_LOC: assert property (ecc |=> error_detail_field[57:45] ==
    $past({err_loc.is_data, err_loc.dword, err_loc.way})) else $error("ecc");
  AST_ECC_SET: assert property (ecc |=> error_detail_field[44:28] ==
    {3'h0, $past(err_loc.set[12:0]), $past(err_loc.bank)}) else $error("set");
  AST_PORT: assert property (tk |=> error_detail_field[27:18] ==
    {$past(err_req.port), 2'h0, $past(err_req.hart[1:0])}) else $error("port");
  AST_CMD: assert property (tk |=> error_detail_field[17:5] == $past(
    {err_req.cmd, err_req.grp, err_req.attr, err_req.size})) else $error("cmd");
  AST_TYPE: assert property (tk && (err_req.ttype[3:2] != 2'h0 ||
    !err_req.ttype[0]) |=> error_detail_field[4:1] == $past(err_req.ttype))
    else $error("type");
  AST_PAR: assert property (tk && err_kind == 4'h4 |=>
    error_detail_field[57:36] == 22'h0) else $error("parity");
  AST_FLK: assert property (tk && err_kind == 4'h5 |=>
    error_detail_field[57:29] == 29'h0) else $error("flock");
  AST_HOLD: assert property (error_held && !reg_wr |=>
    error_held && $stable(error_detail_field)) else $error("hold");
  AST_RDLO: assert property (reg_rd && reg_addr == 4'h0 |=>
    reg_rdata == $past(error_detail_field[31:0])) else $error("read");
  AST_RSVD: assert property (tk && err_req.ttype inside {4'h1, 4'h3} |=>
    error_detail_field[4:1] == 4'h0) else $error("reserved type");
  AST_DEC_RSV: assert property (tk && err_kind == 4'h2 |=>
    {error_detail_field[57], error_detail_field[53]} == 2'h0)
    else $error("decode reserved");

  cover property (ecc);
  cover property (tk && err_kind == 4'h2);
  cover property (err_valid && error_held);
endmodule // ces_capture_chk

// ===== tb/ces_req_model.sv
// requester model: reports one failing transaction per call
`timescale 1ns/1ps

module ces_req_model
  import ces_pkg::*;
(
  input  wire logic clk,
  output logic       err_valid,
  output logic [3:0] err_kind,
  output ces_req_t   err_req,
  output ces_loc_t   err_loc,
  output ces_dec_t   err_dec
);
  initial begin
    err_valid = 1'b0;
    err_kind  = 4'h0;
    err_req   = '0;
    err_loc   = '0;
    err_dec   = '0;
  end

  task automatic send(input logic [3:0] k, input ces_req_t r,
                      input ces_loc_t l, input ces_dec_t d);
    @(posedge clk);
    err_valid <= 1'b1;
    err_kind  <= k;
    err_req   <= r;
    err_loc   <= l;
    err_dec   <= d;
    @(posedge clk);
    err_valid <= 1'b0;
    // unqualified fields show garbage, never the stale report
    err_req   <= ~r;
    err_loc   <= ~l;
    err_dec   <= ~d;
  endtask
endmodule // ces_req_model

// ===== tb/testbench.sv
// self-checking bench for the syndrome capture block
`timescale 1ns/1ps

module testbench
  import ces_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [57:0] det;
  logic [3:0]  kind;
  logic        held;
  logic        err_valid;
  logic [3:0]  err_kind;
  ces_req_t    err_req, r;
  ces_loc_t    err_loc, l;
  ces_dec_t    err_dec;
  logic [57:0] ex;
  int          num_errors = 0;
  int          comparisons = 0;

  always #2 clk = ~clk;

  ces_req_model pm_u(.clk(clk), .err_valid(err_valid), .err_kind(err_kind),
    .err_req(err_req), .err_loc(err_loc), .err_dec(err_dec));
  ces_capture dut_u(.clk(clk), .rst_b(rst_b), .err_valid(err_valid),
    .err_kind(err_kind), .err_req(err_req), .err_loc(err_loc),
    .err_dec(err_dec), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .error_detail_field(det), .error_kind(kind), .error_held(held));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [57:0] exp_f(logic [3:0] k, ces_req_t q,
                                        ces_loc_t c, ces_dec_t d, logic du);
    logic [57:0] e;
    logic [3:0]  t;
    t = (q.ttype inside {4'h1, 4'h3}) ? 4'h0 : q.ttype;
    e = {30'h0, q.port, 2'h0, q.hart[1:0], q.cmd, q.grp, q.attr, q.size, t,
         q.sched & du};
    if (k == 4'h1 || k == 4'h3)
      e[57:28] = {c.is_data, c.dword, c.way, 3'h0, c.set[12:0], c.bank};
    if (k == 4'h2)
      e[57:28] = {1'b0, d.gic_fetch, d.nc_mmio, d.coh_mmio, 1'b0,
        d.linked_load_cond_store | (d.norm & (q.attr != uncached_attr)),
        d.norm & !(q.size inside {CES_SIZE_4B, CES_SIZE_8B}), d.multi,
        d.coh_reg, d.dbg, d.fdc, d.norm, d.hit, d.dcmd, d.dgrp, d.ddst};
    if (k == 4'h4)
      e[35:28] = c.dword;
    return e;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // held, kind and detail outputs compared as one word
  task automatic chk_out(input logic [62:0] got, input logic [62:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t outputs %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // capture one report, read it back whole, then clear it
  task automatic report(input logic [3:0] k, input ces_req_t q,
                        input ces_loc_t c, input ces_dec_t d, input logic du);
    logic [57:0] e;
    int          i;
    e = exp_f(k, q, c, d, du);
    i = 0;
    wr(CES_REG_CTRL, {31'h0, du});
    pm_u.send(k, q, c, d);
    #1;
    while (held !== 1'b1 && i < 8) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (held !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t no capture", $time);
      tally_and_finish();
    end
    chk_out({held, kind, det}, {1'b1, k, e});
    rd(CES_REG_LO, e[31:0]);
    rd(CES_REG_HI, {6'h0, e[57:32]});
    rd(CES_REG_STAT, {24'h0, k, 4'h1});
    wr(CES_REG_CTRL, {30'h0, 1'b1, du});
    rd(CES_REG_STAT, 32'h0);
    chk_out({held, kind, det}, 63'h0);
  endtask

  initial begin
    r = {6'h09, 4'h3, 4'h5, 3'h4, 3'h2, 3'h6, intervene_reply_with_data, 1'b1};
    l = {1'b1, 8'hA5, 4'hF, 16'h1FFF, 1'b1};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a += 2) rd(a[3:0], 32'h0);
    chk_out({held, kind, det}, 63'h0);
    $display("reset done");
    report(4'h1, r, l, '1, 1'b0);
    report(4'h3, r, {1'b0, 8'h01, 4'h0, 16'h0, 1'b0}, '0, 1'b1);
    rd(CES_REG_CTRL, 32'h1);
    $display("ecc done");
    r.attr = 3'h3;
    r.size = 3'h0;
    report(4'h2, r, '1, {9'h155, 5'h15, 4'hA, 3'h5, 6'h2A}, 1'b0);
    r.attr = uncached_attr;
    r.size = CES_SIZE_RPL;
    report(4'h2, r, '0, {9'h0AA, 5'h0A, 4'h5, 3'h2, 6'h15}, 1'b1);
    $display("decode done");
    report(4'h4, r, '1, '1, 1'b0);
    report(4'h5, r, '1, '1, 1'b1);
    for (int t = 0; t < 16; t++) begin
      r.ttype = ces_txn_type_t'(t);
      r.port = 6'(t + 32);
      report(4'h5, r, '0, '0, 1'b0);
    end
    $display("type done");
    pm_u.send(4'h1, r, l, '0);
    pm_u.send(4'h4, ~r, '0, '0);
    ex = exp_f(4'h1, r, l, '0, 1'b0);
    rd(CES_REG_LO, ex[31:0]);
    rd(CES_REG_HI, {6'h0, l.is_data, l.dword, l.way, 3'h0,
                    l.set[12:3]});
    rd(CES_REG_STAT, {24'h0, 4'h1, 4'h1});
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(CES_REG_STAT, 32'h0);
    chk_out({held, kind, det}, 63'h0);
    $display("refuse done");
    tally_and_finish();
  end
endmodule // testbench

bind ces_capture ces_capture_chk chk_u(.clk(clk), .rst_b(rst_b),
  .err_valid(err_valid), .err_kind(err_kind), .err_req(err_req),
  .err_loc(err_loc), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .error_detail_field(error_detail_field),
  .error_held(error_held));
